// ===== design/wrc_pkg.sv
package wrc_pkg;
  // register offsets
  localparam logic [9:0] OFS_IRQ_MASK0 = 10'h100;
  localparam logic [9:0] OFS_TALLY_LO = 10'h102;
  localparam logic [9:0] OFS_TALLY_HI = 10'h103;
  localparam logic [9:0] OFS_ALARM_LO = 10'h104;
  localparam logic [9:0] OFS_ALARM_HI = 10'h105;
  localparam logic [9:0] OFS_WIN_LEN = 10'h106;
  localparam logic [9:0] OFS_TICK_DIV = 10'h107;
  localparam logic [9:0] OFS_SIG_THR = 10'h108;
  localparam logic [9:0] OFS_CARRIER_LO = 10'h109;
  localparam logic [9:0] OFS_CARRIER_MID = 10'h10a;
  localparam logic [9:0] OFS_CARRIER_HI = 10'h10b;
  localparam logic [9:0] OFS_BITRATE_LO = 10'h10c;
  localparam logic [9:0] OFS_BR_DEV_HI = 10'h10d;
  localparam logic [9:0] OFS_DEV_LO = 10'h10e;
  localparam logic [9:0] OFS_CORR_BW = 10'h10f;
  localparam logic [9:0] OFS_POSTFILT = 10'h110;
  localparam logic [9:0] OFS_SPARE = 10'h111;
  localparam logic [9:0] OFS_LOOP_PHASE = 10'h112;
  localparam logic [9:0] OFS_CTRL = 10'h120;
  localparam logic [9:0] OFS_IRQ_STAT = 10'h121;
  localparam logic [9:0] OFS_STATE = 10'h122;
  // field positions
  localparam int MASK_TALLY_BIT = 7;
  localparam int MASK_SIG_BIT = 6;
  localparam int MASK_TIMEOUT_BIT = 4;
  localparam int CTRL_TIMER_EN_BIT = 0;
  localparam int CTRL_SMART_EN_BIT = 1;
  localparam int CTRL_SIG_EN_BIT = 2;
  localparam int CTRL_LOOP_SEL_LSB = 4;
  localparam int DEV_HI_LSB = 4;
  localparam int PHASE_W = 2;
  localparam int LOOP_TUNE_LSB = 2;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_TICK_DIV = 8'h33;
  localparam logic [7:0] RST_POSTFILT = 8'h01;
  // timing
  localparam int TICK_PRESCALE = 128;
  localparam int SIG_OFFSET_DBM = 107;
  localparam int SYS_CLK_KHZ = 200000;
  localparam int TIME_BASE_KHZ = 6500;

  typedef enum logic [1:0] {
    WRC_SLEEP,
    WRC_LISTEN,
    WRC_RX,
    WRC_OFF
  } wrc_state_t;

  typedef struct packed {
    logic [23:0] carrier_word;
    logic [11:0] bitrate;
    logic [11:0] tone_offset;
    logic [7:0] corr_bw;
    logic [1:0] corr_phase;
    logic [7:0] postfilt_bw;
    logic [5:0] rx_loop_tune;
  } wrc_radio_cfg_t;
endpackage

// ===== design/wrc_bank.sv
`timescale 1ns/100ps
module wrc_bank #(
  parameter int CLK_KHZ = wrc_pkg::SYS_CLK_KHZ
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [9:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic wake_timeout_i,
  input wire logic preamble_i,
  input wire logic [7:0] signal_level_i,
  output logic radio_on_o,
  output logic rx_en_o,
  output logic radio_off_state_o,
  output logic irq_o,
  output wrc_pkg::wrc_radio_cfg_t radio_cfg_o,
  output logic [7:0] sig_thr_o
);
  //////////////////////////////////////////////////////////////////////////////
  // register storage; tick derivation and state
  // 200 MHz cycles per 6.5 MHz time-base cycle, rounded down
  localparam int BASE_DIV = CLK_KHZ / wrc_pkg::TIME_BASE_KHZ;
  localparam int PRE_CYC = wrc_pkg::TICK_PRESCALE * BASE_DIV;
  localparam int PRE_W = $clog2(PRE_CYC + 1);

  logic [7:0] bank_ff [wrc_pkg::OFS_ALARM_LO:wrc_pkg::OFS_LOOP_PHASE];
  logic [7:0] mask0_ff;
  logic [7:0] ctrl_ff;
  logic [7:0] stat_ff;
  logic [15:0] tally_ff;
  wrc_pkg::wrc_state_t state_ff;
  logic [PRE_W-1:0] pre_ff;
  logic [7:0] div_cnt_ff;
  logic [7:0] win_cnt_ff;
  logic [2:0] to_sync_ff;
  logic [1:0] pre_sync_ff;
  logic [7:0] lvl_s1_ff;
  logic [7:0] lvl_s2_ff;
  logic [15:0] alarm_level;
  logic tally_evt;
  logic sig_evt;
  logic to_evt;
  logic preamble_s;
  logic tick;
  logic base_tick;
  logic window_done;
  logic [7:0] nxt_stat;

  function automatic logic in_bank(input logic [9:0] a);
    in_bank = (a >= wrc_pkg::OFS_ALARM_LO) && (a <= wrc_pkg::OFS_LOOP_PHASE);
  endfunction

  function automatic logic hit(input logic [9:0] a, input logic [9:0] ofs);
    hit = (a == ofs);
  endfunction

  assign alarm_level = {bank_ff[wrc_pkg::OFS_ALARM_HI], bank_ff[wrc_pkg::OFS_ALARM_LO]};

  //////////////////////////////////////////////////////////////////////////////
  // input synchronisers: timeout is edge-detected after two flops
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      to_sync_ff <= 3'h0;
    end else begin
      to_sync_ff <= {to_sync_ff[1:0], wake_timeout_i};
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pre_sync_ff <= 2'h0;
    end else begin
      pre_sync_ff <= {pre_sync_ff[0], preamble_i};
    end
  end

  // the level word may tear for a cycle while it moves; it only feeds a sticky compare
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lvl_s1_ff <= 8'h00;
      lvl_s2_ff <= 8'h00;
    end else begin
      lvl_s1_ff <= signal_level_i;
      lvl_s2_ff <= lvl_s1_ff;
    end
  end
  assign to_evt = to_sync_ff[1] & ~to_sync_ff[2];
  assign preamble_s = pre_sync_ff[1];

  //////////////////////////////////////////////////////////////////////////////
  // configuration bytes
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = wrc_pkg::OFS_ALARM_LO; i <= wrc_pkg::OFS_LOOP_PHASE; i++) begin
        bank_ff[i] <= wrc_pkg::RST_BYTE;
      end
      bank_ff[wrc_pkg::OFS_TICK_DIV] <= wrc_pkg::RST_TICK_DIV;
      bank_ff[wrc_pkg::OFS_POSTFILT] <= wrc_pkg::RST_POSTFILT;
    end else if (wr_i && in_bank(addr_i)) begin
      if (hit(addr_i, wrc_pkg::OFS_SPARE)) begin
        bank_ff[addr_i] <= wrc_pkg::RST_BYTE;
      end else if (hit(addr_i, wrc_pkg::OFS_POSTFILT) && wdata_i == 8'h00) begin
        bank_ff[addr_i] <= wrc_pkg::RST_POSTFILT;
      end else begin
        bank_ff[addr_i] <= wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mask0_ff <= wrc_pkg::RST_BYTE;
      ctrl_ff <= wrc_pkg::RST_BYTE;
    end else if (wr_i) begin
      if (hit(addr_i, wrc_pkg::OFS_IRQ_MASK0)) begin
        mask0_ff <= wdata_i;
      end
      if (hit(addr_i, wrc_pkg::OFS_CTRL)) begin
        ctrl_ff <= wdata_i;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // wake tally; a software write wins over a same-cycle increment
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tally_ff <= 16'h0000;
    end else if (wr_i && hit(addr_i, wrc_pkg::OFS_TALLY_LO)) begin
      tally_ff <= {tally_ff[15:8], wdata_i};
    end else if (wr_i && hit(addr_i, wrc_pkg::OFS_TALLY_HI)) begin
      tally_ff <= {wdata_i, tally_ff[7:0]};
    end else if (to_evt && ctrl_ff[wrc_pkg::CTRL_TIMER_EN_BIT] && state_ff == wrc_pkg::WRC_SLEEP) begin
      tally_ff <= tally_ff + 16'h0001;
    end
  end

  // compare uses the updated count, one cycle after the increment
  logic to_seen_ff;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      to_seen_ff <= 1'b0;
    end else begin
      to_seen_ff <= to_evt && ctrl_ff[wrc_pkg::CTRL_TIMER_EN_BIT] && state_ff == wrc_pkg::WRC_SLEEP;
    end
  end
  assign tally_evt = to_seen_ff && (tally_ff > alarm_level);

  //////////////////////////////////////////////////////////////////////////////
  // listen timer: base tick every 128 time-base cycles, then divider ticks
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pre_ff <= '0;
    end else if (state_ff != wrc_pkg::WRC_LISTEN || base_tick) begin
      pre_ff <= '0;
    end else begin
      pre_ff <= pre_ff + PRE_W'(1);
    end
  end
  assign base_tick = (pre_ff == PRE_W'(PRE_CYC - 1));

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_cnt_ff <= 8'h00;
    end else if (state_ff != wrc_pkg::WRC_LISTEN) begin
      div_cnt_ff <= 8'h00;
    end else if (base_tick) begin
      div_cnt_ff <= tick ? 8'h00 : div_cnt_ff + 8'h01;
    end
  end

  // tick only fires together with a base tick, so no separate qualifier is needed
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      win_cnt_ff <= 8'h00;
    end else if (state_ff != wrc_pkg::WRC_LISTEN) begin
      win_cnt_ff <= 8'h00;
    end else if (tick) begin
      win_cnt_ff <= win_cnt_ff + 8'h01;
    end
  end
  assign tick = base_tick && (div_cnt_ff + 8'h01 >= bank_ff[wrc_pkg::OFS_TICK_DIV]);
  assign window_done = (win_cnt_ff >= bank_ff[wrc_pkg::OFS_WIN_LEN]);

  // signal level reading is offset by the same 107 dB as the threshold
  assign sig_evt = (state_ff == wrc_pkg::WRC_LISTEN) && ctrl_ff[wrc_pkg::CTRL_SIG_EN_BIT] &&
                   (lvl_s2_ff > bank_ff[wrc_pkg::OFS_SIG_THR]);

  //////////////////////////////////////////////////////////////////////////////
  // wake state machine
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff <= wrc_pkg::WRC_SLEEP;
    end else begin
      unique case (state_ff)
        wrc_pkg::WRC_SLEEP: begin
          if (tally_evt) begin
            state_ff <= wrc_pkg::WRC_OFF;
          end else if (to_seen_ff && ctrl_ff[wrc_pkg::CTRL_SMART_EN_BIT]) begin
            state_ff <= wrc_pkg::WRC_LISTEN;
          end
        end
        wrc_pkg::WRC_LISTEN: begin
          if (preamble_s) begin
            state_ff <= wrc_pkg::WRC_RX;
          end else if (window_done) begin
            state_ff <= wrc_pkg::WRC_SLEEP;
          end
        end
        // reception hands back by software disabling smart listen
        wrc_pkg::WRC_RX: begin
          if (!ctrl_ff[wrc_pkg::CTRL_SMART_EN_BIT]) begin
            state_ff <= wrc_pkg::WRC_SLEEP;
          end
        end
        // radio-off holds until software clears the timer enable bit
        wrc_pkg::WRC_OFF: begin
          if (!ctrl_ff[wrc_pkg::CTRL_TIMER_EN_BIT]) begin
            state_ff <= wrc_pkg::WRC_SLEEP;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sticky status, write one to clear, set wins
  always_comb begin
    nxt_stat = stat_ff;
    if (wr_i && hit(addr_i, wrc_pkg::OFS_IRQ_STAT)) begin
      nxt_stat = stat_ff & ~wdata_i;
    end
    if (tally_evt) begin
      nxt_stat[wrc_pkg::MASK_TALLY_BIT] = 1'b1;
    end
    if (sig_evt) begin
      nxt_stat[wrc_pkg::MASK_SIG_BIT] = 1'b1;
    end
    if (to_seen_ff) begin
      nxt_stat[wrc_pkg::MASK_TIMEOUT_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stat_ff <= 8'h00;
      irq_o <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      irq_o <= |(nxt_stat & mask0_ff);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs and read path
  wrc_pkg::wrc_radio_cfg_t nxt_cfg;
  logic [7:0] nxt_rdata;

  function automatic logic radio_active(input wrc_pkg::wrc_state_t s);
    radio_active = (s == wrc_pkg::WRC_LISTEN) || (s == wrc_pkg::WRC_RX);
  endfunction

  // power and receive enable are separate flops so the receiver could later
  // be held back behind power-up without touching the other pin
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      radio_on_o <= 1'b0;
    end else begin
      radio_on_o <= radio_active(state_ff);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_en_o <= 1'b0;
    end else begin
      rx_en_o <= radio_active(state_ff);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      radio_off_state_o <= 1'b0;
    end else begin
      radio_off_state_o <= (state_ff == wrc_pkg::WRC_OFF);
    end
  end

  // settings are assembled from the bytes each cycle; no latching across bytes
  always_comb begin
    nxt_cfg = '0;
    nxt_cfg.carrier_word = {bank_ff[wrc_pkg::OFS_CARRIER_HI],
      bank_ff[wrc_pkg::OFS_CARRIER_MID], bank_ff[wrc_pkg::OFS_CARRIER_LO]};
    nxt_cfg.bitrate = {bank_ff[wrc_pkg::OFS_BR_DEV_HI][3:0],
      bank_ff[wrc_pkg::OFS_BITRATE_LO]};
    nxt_cfg.tone_offset = {bank_ff[wrc_pkg::OFS_BR_DEV_HI][7:wrc_pkg::DEV_HI_LSB],
      bank_ff[wrc_pkg::OFS_DEV_LO]};
    nxt_cfg.corr_bw = bank_ff[wrc_pkg::OFS_CORR_BW];
    nxt_cfg.corr_phase = bank_ff[wrc_pkg::OFS_LOOP_PHASE][wrc_pkg::PHASE_W-1:0];
    nxt_cfg.postfilt_bw = bank_ff[wrc_pkg::OFS_POSTFILT];
    // loop tune only reaches the synthesizer when a custom receive table is chosen
    if (ctrl_ff[wrc_pkg::CTRL_LOOP_SEL_LSB]) begin
      nxt_cfg.rx_loop_tune = bank_ff[wrc_pkg::OFS_LOOP_PHASE][7:wrc_pkg::LOOP_TUNE_LSB];
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      radio_cfg_o <= '0;
    end else begin
      radio_cfg_o <= nxt_cfg;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sig_thr_o <= 8'h00;
    end else begin
      sig_thr_o <= bank_ff[wrc_pkg::OFS_SIG_THR];
    end
  end

  // read data is zero outside the cycle after a read strobe
  always_comb begin
    nxt_rdata = 8'h00;
    if (rd_i) begin
      if (in_bank(addr_i)) begin
        nxt_rdata = bank_ff[addr_i];
      end else begin
        case (addr_i)
          wrc_pkg::OFS_IRQ_MASK0: begin
            nxt_rdata = mask0_ff;
          end
          wrc_pkg::OFS_TALLY_LO: begin
            nxt_rdata = tally_ff[7:0];
          end
          wrc_pkg::OFS_TALLY_HI: begin
            nxt_rdata = tally_ff[15:8];
          end
          wrc_pkg::OFS_CTRL: begin
            nxt_rdata = ctrl_ff;
          end
          wrc_pkg::OFS_IRQ_STAT: begin
            nxt_rdata = stat_ff;
          end
          wrc_pkg::OFS_STATE: begin
            nxt_rdata = {6'h00, state_ff};
          end
          default: begin
            nxt_rdata = 8'h00;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= nxt_rdata;
    end
  end
endmodule

// ===== tb/wrc_bank_assertions.sv
`timescale 1ns/100ps
module wrc_bank_assertions #(
  parameter int CLK_KHZ = wrc_pkg::SYS_CLK_KHZ
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [9:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic radio_on_o,
  input wire logic rx_en_o,
  input wire logic radio_off_state_o,
  input wire logic irq_o,
  input wire wrc_pkg::wrc_radio_cfg_t radio_cfg_o,
  input wire logic [7:0] sig_thr_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////////////
  // byte lands at the write edge, the output flop one edge later
  property cfg_p(logic [9:0] a, logic [7:0] f, logic [7:0] d);
    wr_i && addr_i == a |=> ##1 (f == $past(d, 2));
  endproperty
  alarm_readback_a: assert property (wr_i && addr_i == 10'h104 ##1 rd_i && addr_i == 10'h104 |=>
    rdata_o == $past(wdata_i, 2)) else $error("alarm low byte readback");
  carrier_hi_a: assert property (cfg_p(10'h10b, radio_cfg_o.carrier_word[23:16], wdata_i))
    else $error("carrier high byte");
  bitrate_hi_a: assert property (cfg_p(10'h10d, {4'h0, radio_cfg_o.bitrate[11:8]},
    {4'h0, wdata_i[3:0]})) else $error("bitrate high nibble");
  tone_hi_a: assert property (cfg_p(10'h10d, {4'h0, radio_cfg_o.tone_offset[11:8]},
    {4'h0, wdata_i[7:4]})) else $error("tone offset high nibble");
  corr_bw_a: assert property (cfg_p(10'h10f, radio_cfg_o.corr_bw, wdata_i))
    else $error("correlator bandwidth");
  corr_phase_a: assert property (cfg_p(10'h112, {6'h00, radio_cfg_o.corr_phase},
    {6'h00, wdata_i[1:0]})) else $error("correlator phase");
  postfilt_min_a: assert property (cfg_p(10'h110, radio_cfg_o.postfilt_bw,
    wdata_i | {7'h00, wdata_i == 8'h00})) else $error("postfilter bandwidth");
  sig_thr_src_a: assert property ($changed(sig_thr_o) |->
    $past(wr_i && addr_i == 10'h108) || $past(wr_i && addr_i == 10'h108, 2))
    else $error("signal threshold changed without write");
  off_quiet_a: assert property (radio_off_state_o |-> !radio_on_o && !rx_en_o)
    else $error("radio active in off state");
  rx_follow_a: assert property (rx_en_o == radio_on_o)
    else $error("receiver enable apart from radio power");
  cover property ($rose(radio_off_state_o));
  cover property ($rose(irq_o));
  cover property ($fell(radio_on_o) && !radio_off_state_o);
endmodule

bind wrc_bank wrc_bank_assertions #(.CLK_KHZ(CLK_KHZ)) u_chk (.clk_i(clk_i), .rstn_i(rstn_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .radio_on_o(radio_on_o), .rx_en_o(rx_en_o), .radio_off_state_o(radio_off_state_o),
  .irq_o(irq_o), .radio_cfg_o(radio_cfg_o), .sig_thr_o(sig_thr_o));

// ===== tb/wrc_bank_tb.sv
`timescale 1ns/100ps
module wrc_bank_tb;
  // one base tick is 128 clocks here, so listen windows stay short
  localparam int CLK_KHZ = 6500;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [9:0] addr_i = 10'h000;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic wake_i = 1'b0;
  logic pre_i = 1'b0;
  logic [7:0] lvl_i = 8'h00;
  logic [7:0] rdata_o;
  logic on_o, rx_o, off_o, irq_o;
  wrc_pkg::wrc_radio_cfg_t cfg_o;
  logic [7:0] thr_o;
  int fail_count = 0;
  int n_compared = 0;

  wrc_bank #(.CLK_KHZ(CLK_KHZ)) u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .wake_timeout_i(wake_i),
    .preamble_i(pre_i), .signal_level_i(lvl_i), .radio_on_o(on_o), .rx_en_o(rx_o),
    .radio_off_state_o(off_o), .irq_o(irq_o), .radio_cfg_o(cfg_o), .sig_thr_o(thr_o));

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////
  task automatic chk(input string w, input logic [23:0] e, input logic [23:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic chkb(input string w, input logic e, input logic g);
    chk(w, {23'h0, e}, {23'h0, g});
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk("read", {16'h0, e}, {16'h0, rdata_o});
  endtask
  // write then read the same byte with no gap
  task automatic wrrd(input logic [9:0] a, input logic [7:0] d);
    wr(a, d);
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk("readback", {16'h0, d}, {16'h0, rdata_o});
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // pulse is held three clocks so the two-flop sync cannot miss it
  task automatic wake();
    @(posedge clk_i);
    wake_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    wake_i <= 1'b0;
    settle(8);
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    rd(10'h107, 8'h33);
    rd(10'h110, 8'h01);
    rd(10'h104, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_cfg();
    wr(10'h109, 8'h11);
    wr(10'h10a, 8'h22);
    wr(10'h10b, 8'h33);
    wr(10'h10c, 8'h44);
    wr(10'h10d, 8'ha5);
    wr(10'h10e, 8'h66);
    wr(10'h10f, 8'h77);
    wr(10'h112, 8'ha7);
    wr(10'h108, 8'h55);
    settle(2);
    chk("carrier", 24'h332211, cfg_o.carrier_word);
    chk("bitrate", 24'h000544, {12'h0, cfg_o.bitrate});
    chk("tone", 24'h000a66, {12'h0, cfg_o.tone_offset});
    chk("corr bw", 24'h000077, {16'h0, cfg_o.corr_bw});
    chk("phase", 24'h000003, {22'h0, cfg_o.corr_phase});
    chk("sig thr", 24'h000055, {16'h0, thr_o});
    for (int m = 0; m < 4; m++) begin
      wr(10'h120, 8'(m << 4));
      settle(2);
      chk("loop tune", (m % 2) ? 24'h29 : 24'h0, {18'h0, cfg_o.rx_loop_tune});
    end
    wr(10'h120, 8'h00);
    wr(10'h110, 8'h00);
    rd(10'h110, 8'h01);
    wr(10'h111, 8'hff);
    rd(10'h111, 8'h00);
    rd(10'h1ff, 8'h00);
    $display("test config done");
  endtask
  task automatic t_alarm();
    wr(10'h102, 8'hff);
    wr(10'h103, 8'h00);
    wrrd(10'h104, 8'h00);
    wrrd(10'h105, 8'h01);
    wr(10'h100, 8'h00);
    wr(10'h120, 8'h01);
    wake();
    chkb("off at equal", 1'b0, off_o);
    rd(10'h103, 8'h01);
    wake();
    chkb("off above", 1'b1, off_o);
    chkb("irq masked", 1'b0, irq_o);
    rd(10'h122, 8'h03);
    wr(10'h100, 8'h80);
    settle(2);
    chkb("irq unmasked", 1'b1, irq_o);
    wr(10'h121, 8'h80);
    settle(2);
    chkb("irq cleared", 1'b0, irq_o);
    wr(10'h120, 8'h00);
    settle(2);
    chkb("off left", 1'b0, off_o);
    $display("test alarm done");
  endtask
  task automatic t_listen();
    wr(10'h102, 8'h00);
    wr(10'h104, 8'hff);
    wr(10'h105, 8'hff);
    wr(10'h106, 8'h02);
    wr(10'h107, 8'h01);
    wr(10'h120, 8'h03);
    wake();
    chkb("listen on", 1'b1, on_o);
    chkb("rx enable", 1'b1, rx_o);
    settle(100);
    chkb("in window", 1'b1, on_o);
    settle(170);
    chkb("window over", 1'b0, on_o);
    rd(10'h122, 8'h00);
    wake();
    pre_i <= 1'b1;
    settle(300);
    chkb("rx held", 1'b1, on_o);
    rd(10'h122, 8'h02);
    wr(10'h120, 8'h00);
    pre_i <= 1'b0;
    settle(4);
    chkb("rx left", 1'b0, on_o);
    wr(10'h121, 8'hff);
    wr(10'h100, 8'h40);
    wr(10'h120, 8'h07);
    lvl_i <= 8'h55;
    wake();
    chkb("level at thr", 1'b0, irq_o);
    lvl_i <= 8'h56;
    settle(4);
    chkb("level above", 1'b1, irq_o);
    lvl_i <= 8'h00;
    wr(10'h120, 8'h00);
    wr(10'h121, 8'h40);
    settle(2);
    chkb("level cleared", 1'b0, irq_o);
    $display("test listen done");
  endtask
  ////////////////////////////////////////
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_cfg();
    t_alarm();
    t_listen();
    end_sim();
  end
  // the whole run needs about 800 clocks
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    $display("Error watchdog expected finish seen hang");
    end_sim();
  end
endmodule
